//--- iscm_consts.vh
`ifndef ISCM_CONSTS_VH
`define ISCM_CONSTS_VH
// ==========================================================
// Access targets
`define ISCM_TGT_ONCHIP_MEM 3'h0
`define ISCM_TGT_MOD_8 3'h1
`define ISCM_TGT_MOD_16 3'h2
`define ISCM_TGT_EXT8_2ST 3'h3
`define ISCM_TGT_EXT8_3ST 3'h4
`define ISCM_TGT_EXT16_2ST 3'h5
`define ISCM_TGT_EXT16_3ST 3'h6
// ==========================================================
// Cycle kinds
`define ISCM_KIND_FETCH 2'h0
`define ISCM_KIND_BYTE 2'h1
`define ISCM_KIND_WORD 2'h2
`define ISCM_KIND_INTERNAL 2'h3
// ==========================================================
// State costs
`define ISCM_COST_ONE 8'h01
`define ISCM_COST_TWO 8'h02
`define ISCM_COST_THREE 8'h03
`define ISCM_COST_FOUR 8'h04
`define ISCM_COST_SIX 8'h06
// ==========================================================
// Opcode select bit
`define ISCM_OPC_MSB 7
// ==========================================================
// Reset values
`define ISCM_TOTAL_RST 16'h0000
`define ISCM_FLAG_RST 1'b0
`endif

//--- iscm_cycle_cost.v
`timescale 1ns/1ps
`include "iscm_consts.vh"
module iscm_cycle_cost (
    input wire [2:0] target_i,
    input wire [1:0] kind_i,
    input wire [3:0] wait_i,
    output reg [7:0] cost_o
);
    wire [7:0] m_w;
    assign m_w = {4'h0, wait_i};
    always @* begin
        cost_o = `ISCM_COST_ONE;
        if (kind_i == `ISCM_KIND_INTERNAL) begin
            cost_o = `ISCM_COST_ONE; // [RQ8]
        end else begin
            case (target_i) // [RQ3]
                `ISCM_TGT_ONCHIP_MEM: cost_o = `ISCM_COST_ONE; // [RQ4]
                `ISCM_TGT_MOD_8: begin
                    if (kind_i == `ISCM_KIND_BYTE) begin
                        cost_o = `ISCM_COST_TWO; // [RQ5]
                    end else begin
                        cost_o = `ISCM_COST_FOUR; // [RQ5]
                    end
                end
                `ISCM_TGT_MOD_16: cost_o = `ISCM_COST_TWO; // [RQ5]
                `ISCM_TGT_EXT8_2ST: begin
                    if (kind_i == `ISCM_KIND_BYTE) begin
                        cost_o = `ISCM_COST_TWO; // [RQ6]
                    end else begin
                        cost_o = `ISCM_COST_FOUR; // [RQ6]
                    end
                end
                `ISCM_TGT_EXT8_3ST: begin
                    if (kind_i == `ISCM_KIND_BYTE) begin
                        cost_o = `ISCM_COST_THREE + m_w; // [RQ6] [RQ9]
                    end else begin
                        cost_o = `ISCM_COST_SIX + {m_w[6:0], 1'b0}; // [RQ6]
                    end
                end
                `ISCM_TGT_EXT16_2ST: cost_o = `ISCM_COST_TWO; // [RQ7]
                `ISCM_TGT_EXT16_3ST: cost_o = `ISCM_COST_THREE + m_w; // [RQ7]
                default: cost_o = `ISCM_COST_ONE;
            endcase
        end
    end
endmodule

//--- iscm_state_count.v
`timescale 1ns/1ps
`include "iscm_consts.vh"
// What this block does
// RQ1: Total states equal the sum of each cycle type count times its cost.
// RQ2: Each instruction gives six separate cycle type counts.
// RQ3: A cycle cost depends on target, bus width and access size.
// RQ4: On-chip memory cycles take one state.
// RQ5: Module 8-bit bus costs 4 fetch/word and 2 byte; 16-bit bus costs 2.
// RQ6: External 8-bit: 4 or 2 in 2-state mode, 6+2m or 3+m in 3-state.
// RQ7: External 16-bit costs 2 in 2-state and 3+m in 3-state mode.
// RQ8: Internal operation cycles always cost one state.
// RQ9: m is the external wait count and lengthens 3-state access only.
// RQ10: Top bit of the eighth opcode byte selects between two groups.
// RQ11: Branch address and stack cycles cost as instruction fetch does.
module iscm_state_count (
    input wire clk_sys_i,
    input wire reset_n_i,
    input wire calc_i,
    input wire [3:0] fetch_cnt_i,
    input wire [3:0] branch_cnt_i,
    input wire [3:0] stack_cnt_i,
    input wire [3:0] byte_cnt_i,
    input wire [3:0] word_cnt_i,
    input wire [7:0] internal_cnt_i,
    input wire [2:0] code_tgt_i,
    input wire [2:0] stack_tgt_i,
    input wire [2:0] data_tgt_i,
    input wire [3:0] wait_i,
    input wire [7:0] eighth_opcode_byte_high_i,
    output reg [15:0] total_states_o,
    output reg group_sel_o,
    output reg done_o
);

    // ==========================================================
    // Per-cycle state costs
    wire [7:0] fetch_cost;
    wire [7:0] branch_addr_read_cost;
    wire [7:0] stack_cycle_cost;
    wire [7:0] byte_access_cost;
    wire [7:0] word_access_cost;
    wire [7:0] internal_op_cost;

    // ==========================================================
    // Counts at the result width
    wire [15:0] fetch_cnt_w;
    wire [15:0] branch_cnt_w;
    wire [15:0] stack_cnt_w;
    wire [15:0] byte_cnt_w;
    wire [15:0] word_cnt_w;
    wire [15:0] internal_cnt_w;

    // ==========================================================
    // Costs at the result width
    wire [15:0] fetch_cost_w;
    wire [15:0] branch_cost_w;
    wire [15:0] stack_cost_w;
    wire [15:0] byte_cost_w;
    wire [15:0] word_cost_w;
    wire [15:0] internal_cost_w;

    // ==========================================================
    // Weighted terms
    wire [15:0] fetch_term;
    wire [15:0] branch_term;
    wire [15:0] stack_term;
    wire [15:0] byte_term;
    wire [15:0] word_term;
    wire [15:0] internal_term;

    // ==========================================================
    // Adder tree
    wire [15:0] code_pair;
    wire [15:0] stack_pair;
    wire [15:0] data_pair;
    wire [15:0] access_sum;
    wire [15:0] sum_nxt;

    // ==========================================================
    // Group select
    wire group_bit;

    // ==========================================================
    // Next values of the result registers
    reg [15:0] total_nxt;
    reg group_nxt;
    reg done_nxt;

    // ==========================================================
    // Cost units; branch and stack reuse fetch pricing
    // Fetch cycles, priced on the code target
    iscm_cycle_cost u_fetch (
        .target_i(code_tgt_i),
        .kind_i(`ISCM_KIND_FETCH),
        .wait_i(wait_i),
        .cost_o(fetch_cost)
    );

    // Branch address reads: code target, fetch pricing
    iscm_cycle_cost u_branch ( // [RQ11]
        .target_i(code_tgt_i),
        .kind_i(`ISCM_KIND_FETCH),
        .wait_i(wait_i),
        .cost_o(branch_addr_read_cost)
    );

    // Stack cycles: own target, fetch pricing
    iscm_cycle_cost u_stack ( // [RQ11]
        .target_i(stack_tgt_i),
        .kind_i(`ISCM_KIND_FETCH),
        .wait_i(wait_i),
        .cost_o(stack_cycle_cost)
    );

    // Byte data cycles on the data target
    iscm_cycle_cost u_byte (
        .target_i(data_tgt_i),
        .kind_i(`ISCM_KIND_BYTE),
        .wait_i(wait_i),
        .cost_o(byte_access_cost)
    );

    // Word data cycles on the data target
    iscm_cycle_cost u_word (
        .target_i(data_tgt_i),
        .kind_i(`ISCM_KIND_WORD),
        .wait_i(wait_i),
        .cost_o(word_access_cost)
    );

    // Internal cycles; the target does not matter
    iscm_cycle_cost u_int (
        .target_i(data_tgt_i),
        .kind_i(`ISCM_KIND_INTERNAL),
        .wait_i(wait_i),
        .cost_o(internal_op_cost)
    );

    // ==========================================================
    // Zero extension keeps each product at full width
    assign fetch_cnt_w = {12'h000, fetch_cnt_i}; // [RQ2]
    assign branch_cnt_w = {12'h000, branch_cnt_i}; // [RQ2]
    assign stack_cnt_w = {12'h000, stack_cnt_i}; // [RQ2]
    assign byte_cnt_w = {12'h000, byte_cnt_i}; // [RQ2]
    assign word_cnt_w = {12'h000, word_cnt_i}; // [RQ2]
    assign internal_cnt_w = {8'h00, internal_cnt_i}; // [RQ2]

    assign fetch_cost_w = {8'h00, fetch_cost};
    assign branch_cost_w = {8'h00, branch_addr_read_cost};
    assign stack_cost_w = {8'h00, stack_cycle_cost};
    assign byte_cost_w = {8'h00, byte_access_cost};
    assign word_cost_w = {8'h00, word_access_cost};
    assign internal_cost_w = {8'h00, internal_op_cost};

    // ==========================================================
    // Products
    assign fetch_term = fetch_cnt_w * fetch_cost_w; // [RQ1]
    assign branch_term = branch_cnt_w * branch_cost_w; // [RQ1]
    assign stack_term = stack_cnt_w * stack_cost_w; // [RQ1]
    assign byte_term = byte_cnt_w * byte_cost_w; // [RQ1]
    assign word_term = word_cnt_w * word_cost_w; // [RQ1]
    assign internal_term = internal_cnt_w * internal_cost_w; // [RQ1]

    // ==========================================================
    // Sum; the worst case stays far below the 16-bit limit
    assign code_pair = fetch_term + branch_term;
    assign stack_pair = stack_term + internal_term;
    assign data_pair = byte_term + word_term;
    assign access_sum = code_pair + stack_pair;
    assign sum_nxt = access_sum + data_pair; // [RQ1]

    // ==========================================================
    // Group select from the top opcode bit
    assign group_bit = eighth_opcode_byte_high_i[`ISCM_OPC_MSB]; // [RQ10]

    // ==========================================================
    // Next values; total and group hold until the next request, done lasts one cycle
    always @* begin
        total_nxt = total_states_o;
        if (calc_i) begin
            total_nxt = sum_nxt; // [RQ1]
        end
    end

    always @* begin
        group_nxt = group_sel_o;
        if (calc_i) begin
            group_nxt = group_bit; // [RQ10]
        end
    end

    always @* begin
        done_nxt = 1'b0;
        if (calc_i) begin
            done_nxt = 1'b1;
        end
    end

    // ==========================================================
    // Result registers, synchronous reset
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            total_states_o <= `ISCM_TOTAL_RST;
        end else begin
            total_states_o <= total_nxt; // [RQ1]
        end
    end

    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            group_sel_o <= `ISCM_FLAG_RST;
        end else begin
            group_sel_o <= group_nxt; // [RQ10]
        end
    end

    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            done_o <= `ISCM_FLAG_RST;
        end else begin
            done_o <= done_nxt;
        end
    end
endmodule

//--- iscm_state_count_assertions.sv
`timescale 1ns/1ps
module iscm_state_count_chk (
    input logic clk_sys_i,
    input logic reset_n_i,
    input logic calc_i,
    input logic [3:0] fetch_cnt_i,
    input logic [3:0] branch_cnt_i,
    input logic [3:0] stack_cnt_i,
    input logic [3:0] byte_cnt_i,
    input logic [3:0] word_cnt_i,
    input logic [7:0] internal_cnt_i,
    input logic [2:0] code_tgt_i,
    input logic [2:0] stack_tgt_i,
    input logic [2:0] data_tgt_i,
    input logic [3:0] wait_i,
    input logic [7:0] eighth_opcode_byte_high_i,
    input logic [15:0] total_states_o,
    input logic group_sel_o,
    input logic done_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    wire q = (branch_cnt_i | stack_cnt_i | word_cnt_i) == 4'h0;
    wire [15:0] s = fetch_cnt_i + branch_cnt_i + stack_cnt_i + byte_cnt_i
        + word_cnt_i + internal_cnt_i;
    wire t0 = (code_tgt_i | stack_tgt_i | data_tgt_i) == 3'h0;
    property p_done;
        calc_i |=> done_o ##1 (done_o == $past(calc_i));
    endproperty
    a_done: assert property (p_done) else $error("no done");
    property p_idle;
        !calc_i |=> !done_o && $stable(total_states_o);
    endproperty
    a_idle: assert property (p_idle) else $error("idle change");
    property p_grp;
        calc_i |=> group_sel_o == $past(eighth_opcode_byte_high_i[7]);
    endproperty
    a_grp: assert property (p_grp) else $error("group");
    property p_int;
        calc_i && q && fetch_cnt_i == 4'h0 && byte_cnt_i == 4'h0
        |=> total_states_o == $past(internal_cnt_i);
    endproperty
    a_int: assert property (p_int) else $error("internal");
    property p_mem;
        calc_i && t0 |=> total_states_o == $past(s);
    endproperty
    a_mem: assert property (p_mem) else $error("onchip");
    property p_mod;
        calc_i && q && byte_cnt_i == 4'h0 && internal_cnt_i == 8'h0
        && code_tgt_i == 3'h1
        |=> total_states_o == 4 * $past(fetch_cnt_i);
    endproperty
    a_mod: assert property (p_mod) else $error("mod8 fetch");
    property p_wt;
        calc_i && q && fetch_cnt_i == 4'h0 && internal_cnt_i == 8'h0
        && data_tgt_i == 3'h6
        |=> total_states_o == $past(byte_cnt_i) * ($past(wait_i) + 3);
    endproperty
    a_wt: assert property (p_wt) else $error("ext16 wait");
    property p_hold;
        done_o |-> $past(calc_i);
    endproperty
    a_hold: assert property (p_hold) else $error("done width");
    c_grp: cover property (calc_i && eighth_opcode_byte_high_i[7]);
    c_wt: cover property (calc_i && wait_i != 4'h0);
    c_mem: cover property (calc_i && t0);
    c_split: cover property (calc_i && stack_tgt_i != code_tgt_i);
endmodule
bind iscm_state_count iscm_state_count_chk chk_i (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .calc_i(calc_i),
    .fetch_cnt_i(fetch_cnt_i),
    .branch_cnt_i(branch_cnt_i),
    .stack_cnt_i(stack_cnt_i),
    .byte_cnt_i(byte_cnt_i),
    .word_cnt_i(word_cnt_i),
    .internal_cnt_i(internal_cnt_i),
    .code_tgt_i(code_tgt_i),
    .stack_tgt_i(stack_tgt_i),
    .data_tgt_i(data_tgt_i),
    .wait_i(wait_i),
    .eighth_opcode_byte_high_i(eighth_opcode_byte_high_i),
    .total_states_o(total_states_o),
    .group_sel_o(group_sel_o),
    .done_o(done_o)
);

//--- iscm_bus_env.sv
`timescale 1ns/1ps
// Far-side bus map: stack shares the code target unless split off
module iscm_bus_env (
    input wire [2:0] code_sel_i,
    input wire [2:0] stack_sel_i,
    input wire stack_split_i,
    input wire [2:0] data_sel_i,
    input wire [3:0] wait_sel_i,
    output wire [2:0] code_tgt_o,
    output wire [2:0] stack_tgt_o,
    output wire [2:0] data_tgt_o,
    output wire [3:0] wait_o
);
    assign code_tgt_o = code_sel_i;
    assign stack_tgt_o = stack_split_i ? stack_sel_i : code_sel_i;
    assign data_tgt_o = data_sel_i;
    assign wait_o = wait_sel_i;
endmodule

//--- tb_instr_state_count_model.sv
`timescale 1ns/1ps
module tb_instr_state_count_model;
    logic clk_sys_i = 0, reset_n_i = 0, calc_i = 0;
    logic [3:0] fi = 0, bi = 0, si = 0, yi = 0, wi = 0, m = 0;
    logic [7:0] ni = 0, e = 0;
    logic [2:0] cs = 0, ds = 0, ss = 0;
    logic sp = 0;
    wire [2:0] ct, st, dt;
    wire [3:0] wt;
    wire [15:0] tot;
    wire grp, done;
    int failures = 0, n_checks = 0;
    iscm_bus_env iscm_bus_env_i (.code_sel_i(cs), .stack_sel_i(ss),
        .stack_split_i(sp), .data_sel_i(ds), .wait_sel_i(m),
        .code_tgt_o(ct), .stack_tgt_o(st), .data_tgt_o(dt), .wait_o(wt));
    iscm_state_count iscm_state_count_i (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .calc_i(calc_i), .fetch_cnt_i(fi),
        .branch_cnt_i(bi), .stack_cnt_i(si), .byte_cnt_i(yi), .word_cnt_i(wi),
        .internal_cnt_i(ni), .code_tgt_i(ct), .stack_tgt_i(st),
        .data_tgt_i(dt), .wait_i(wt), .eighth_opcode_byte_high_i(e),
        .total_states_o(tot), .group_sel_o(grp), .done_o(done));
    initial forever #25 clk_sys_i = ~clk_sys_i;
    task chk(input logic [16:0] got, input logic [16:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task run(input logic [3:0] i, j, k, l, w, input logic [7:0] n,
        input logic [2:0] c, d, input logic [3:0] mw, input logic [15:0] x);
        {fi, bi, si, yi, wi, ni, cs, ds, m} = {i, j, k, l, w, n, c, d, mw};
        e = e ^ 8'h81;
        calc_i = 1'b1;
        @(posedge clk_sys_i) #1 calc_i = 1'b0;
        chk({done, tot}, {1'b1, x});
        chk({16'h0000, grp}, {16'h0000, e[7]});
        @(posedge clk_sys_i) #1 chk({done, tot}, {1'b0, x});
    endtask
    task t_examples;
        run(2, 0, 0, 2, 0, 0, 6, 1, 1, 12);
        run(2, 2, 2, 0, 0, 0, 6, 6, 1, 24);
    endtask
    task t_ext;
        run(1, 0, 0, 1, 1, 3, 4, 4, 2, 28);
        run(1, 0, 0, 1, 1, 0, 3, 3, 5, 10);
        run(0, 0, 0, 3, 0, 0, 0, 6, 2, 15);
    endtask
    task t_onchip;
        run(15, 15, 15, 15, 15, 255, 0, 0, 0, 330);
        run(0, 0, 0, 0, 0, 9, 5, 6, 7, 9);
    endtask
    task t_mod;
        run(3, 0, 0, 0, 0, 0, 1, 1, 0, 12);
        run(0, 0, 0, 1, 2, 0, 0, 1, 0, 10);
        run(1, 0, 0, 1, 1, 0, 2, 5, 0, 6);
        run(1, 0, 0, 1, 1, 0, 7, 7, 3, 3);
    endtask
    task t_split;
        sp = 1'b1;
        ss = 3'h0;
        run(1, 0, 2, 0, 0, 0, 4, 0, 1, 10);
        ss = 3'h1;
        run(0, 0, 1, 0, 0, 0, 0, 0, 0, 4);
        sp = 1'b0;
    endtask
    task t_reset;
        e = 8'h00;
        run(3, 0, 0, 0, 0, 0, 1, 1, 0, 12);
        reset_n_i = 1'b0;
        @(posedge clk_sys_i) #1 chk({done, tot}, 17'h00000);
        chk({16'h0000, grp}, 17'h00000);
        reset_n_i = 1'b1;
        run(1, 0, 0, 0, 0, 0, 0, 0, 0, 1);
    endtask
    task tally_and_finish;
        if (failures == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_i);
        #1 reset_n_i = 1'b1;
        t_examples;
        t_ext;
        t_onchip;
        t_mod;
        t_split;
        t_reset;
        tally_and_finish;
    end
    initial begin
        #20000;
        failures++;
        tally_and_finish;
    end
endmodule
